/* File: reset_init_pkg.sv */
// Package: register offsets, reset values and bus carriers for reset init
package reset_init_pkg;

    localparam logic [31:0] RV_PC       = 32'hfffffff0;
    localparam logic [31:0] RV_GPR0     = 32'h00000000;
    localparam logic [31:0] RV_STAT_WORD = 32'h00008000;
    localparam logic [31:0] RV_TASK_CTL  = 32'h000000e0;
    localparam logic [15:0] RV_FATAL    = 16'h0000;
    localparam logic [15:0] RV_EXC      = 16'hfff0;
    localparam logic [15:0] RV_PDIR     = 16'h03ff;
    localparam logic [15:0] RV_PFSEL    = 16'h0000;
    localparam logic [7:0]  RV_BCTS     = 8'h01;
    localparam logic [7:0]  RV_WAIT     = 8'h77;
    localparam logic [7:0]  RV_DRAM     = 8'h81;
    localparam logic [7:0]  RV_REFR     = 8'h80;
    localparam logic [7:0]  RV_PROM     = 8'h80;
    localparam logic [15:0] RV_DMACTL   = 16'h0000;
    localparam logic [15:0] RV_TUM      = 16'h0a00;
    localparam logic [7:0]  RV_TOC      = 8'h03;
    localparam logic [7:0]  RV_TZERO    = 8'h00;
    localparam logic [7:0]  RV_SZERO    = 8'h00;
    localparam logic [15:0] RV_IMASK    = 16'hffff;
    localparam logic [15:0] RV_IZERO    = 16'h0000;
    localparam logic [7:0]  RV_IPRIO    = 8'he4;
    localparam logic [7:0]  RV_WDT      = 8'h00;
    localparam logic [7:0]  RV_CLK      = 8'h03;
    localparam logic [7:0]  RV_STBY     = 8'h00;

    localparam int NUM_REGS     = 48;
    localparam int HOLD_CYCLES  = 4;
    localparam int FETCH_CYCLES = 30;

    // Word index of each register; byte address is index times four
    localparam logic [5:0] IX_PC     = 6'h00;
    localparam logic [5:0] IX_GPR0   = 6'h01;
    localparam logic [5:0] IX_STAT_WORD = 6'h02;
    localparam logic [5:0] IX_TASK_CTL  = 6'h03;
    localparam logic [5:0] IX_FATAL  = 6'h04;
    localparam logic [5:0] IX_EXC    = 6'h05;
    localparam logic [5:0] IX_PDIR   = 6'h06;
    localparam logic [5:0] IX_PFSEL  = 6'h07;
    localparam logic [5:0] IX_BCTS   = 6'h08;
    localparam logic [5:0] IX_WAITA  = 6'h09;
    localparam logic [5:0] IX_WAITB  = 6'h0a;
    localparam logic [5:0] IX_WAITC  = 6'h0b;
    localparam logic [5:0] IX_DRAM   = 6'h0c;
    localparam logic [5:0] IX_REFR   = 6'h0d;
    localparam logic [5:0] IX_PROM   = 6'h0e;
    localparam logic [5:0] IX_DMAA   = 6'h0f;
    localparam logic [5:0] IX_DMAB   = 6'h10;
    localparam logic [5:0] IX_TUM    = 6'h11;
    localparam logic [5:0] IX_TOC    = 6'h12;
    localparam logic [5:0] IX_TMCA   = 6'h13;
    localparam logic [5:0] IX_TMCB   = 6'h14;
    localparam logic [5:0] IX_TOVF   = 6'h15;
    localparam logic [5:0] IX_TMA    = 6'h16;
    localparam logic [5:0] IX_TMB    = 6'h17;
    localparam logic [5:0] IX_UMODE  = 6'h18;
    localparam logic [5:0] IX_USTAT  = 6'h19;
    localparam logic [5:0] IX_SMODE  = 6'h1a;
    localparam logic [5:0] IX_BAUD_PRE = 6'h1b;
    localparam logic [5:0] IX_IMASK  = 6'h1c;
    localparam logic [5:0] IX_IREQ   = 6'h1d;
    localparam logic [5:0] IX_ICLR   = 6'h1e;
    localparam logic [5:0] IX_IPRIO  = 6'h1f;
    localparam logic [5:0] IX_WDT    = 6'h20;
    localparam logic [5:0] IX_CLK    = 6'h21;
    localparam logic [5:0] IX_STBY   = 6'h22;
    // 0x23..0x2e: registers without a reset value
    localparam logic [5:0] IX_UNDEF0 = 6'h23;
    localparam logic [5:0] IX_STATUS = 6'h2f;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

endpackage : reset_init_pkg

/* File: reset_register_initializer.sv */
// Reset-value register bank with APB access and reset sequencing
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module reset_register_initializer #(
    parameter int HOLD_CYC  = reset_init_pkg::HOLD_CYCLES,
    parameter int FETCH_CYC = reset_init_pkg::FETCH_CYCLES
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    input  wire logic                     bus_hold_request_i,
    input  wire reset_init_pkg::apb_req_s apb_req_i,
    output      reset_init_pkg::apb_rsp_s apb_rsp_o,
    output      logic                     int_reset_o,
    output      logic                     fetch_start_o
);

    typedef enum logic [1:0] {
        ST_IN_RESET,
        ST_STRETCH,
        ST_RUN
    } seq_e;

    localparam int NR = reset_init_pkg::NUM_REGS;

    logic [31:0] regs_r [NR];
    seq_e        seq_r;
    logic [5:0]  low_cnt_r;
    logic [3:0]  hold_cnt_r;
    logic        fetch_done_r;
    logic        int_reset_r;
    logic        fetch_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        acc;
    logic [5:0]  idx;
    logic        mapped;
    logic        commit;

    // Reset value for registers that have one
    function automatic logic [32:0] reset_val(input logic [5:0] i);
        case (i)
            reset_init_pkg::IX_PC:
                reset_val = {1'b1, reset_init_pkg::RV_PC};
            reset_init_pkg::IX_GPR0:
                reset_val = {1'b1, reset_init_pkg::RV_GPR0};
            reset_init_pkg::IX_STAT_WORD:
                reset_val = {1'b1, reset_init_pkg::RV_STAT_WORD};
            reset_init_pkg::IX_TASK_CTL:
                reset_val = {1'b1, reset_init_pkg::RV_TASK_CTL};
            reset_init_pkg::IX_FATAL:
                reset_val = {17'h10000, reset_init_pkg::RV_FATAL};
            reset_init_pkg::IX_EXC:
                reset_val = {17'h10000, reset_init_pkg::RV_EXC};
            reset_init_pkg::IX_PDIR:
                reset_val = {17'h10000, reset_init_pkg::RV_PDIR};
            reset_init_pkg::IX_PFSEL:
                reset_val = {17'h10000, reset_init_pkg::RV_PFSEL};
            reset_init_pkg::IX_BCTS:
                reset_val = {25'h1000000, reset_init_pkg::RV_BCTS};
            reset_init_pkg::IX_WAITA,
            reset_init_pkg::IX_WAITB,
            reset_init_pkg::IX_WAITC:
                reset_val = {25'h1000000, reset_init_pkg::RV_WAIT};
            reset_init_pkg::IX_DRAM:
                reset_val = {25'h1000000, reset_init_pkg::RV_DRAM};
            reset_init_pkg::IX_REFR:
                reset_val = {25'h1000000, reset_init_pkg::RV_REFR};
            reset_init_pkg::IX_PROM:
                reset_val = {25'h1000000, reset_init_pkg::RV_PROM};
            reset_init_pkg::IX_DMAA,
            reset_init_pkg::IX_DMAB:
                reset_val = {17'h10000, reset_init_pkg::RV_DMACTL};
            reset_init_pkg::IX_TUM:
                reset_val = {17'h10000, reset_init_pkg::RV_TUM};
            reset_init_pkg::IX_TOC:
                reset_val = {25'h1000000, reset_init_pkg::RV_TOC};
            reset_init_pkg::IX_TMCA,
            reset_init_pkg::IX_TMCB,
            reset_init_pkg::IX_TOVF,
            reset_init_pkg::IX_TMA,
            reset_init_pkg::IX_TMB:
                reset_val = {25'h1000000, reset_init_pkg::RV_TZERO};
            reset_init_pkg::IX_UMODE,
            reset_init_pkg::IX_USTAT,
            reset_init_pkg::IX_SMODE,
            reset_init_pkg::IX_BAUD_PRE:
                reset_val = {25'h1000000, reset_init_pkg::RV_SZERO};
            reset_init_pkg::IX_IMASK:
                reset_val = {17'h10000, reset_init_pkg::RV_IMASK};
            reset_init_pkg::IX_IREQ,
            reset_init_pkg::IX_ICLR:
                reset_val = {17'h10000, reset_init_pkg::RV_IZERO};
            reset_init_pkg::IX_IPRIO:
                reset_val = {25'h1000000, reset_init_pkg::RV_IPRIO};
            reset_init_pkg::IX_WDT:
                reset_val = {25'h1000000, reset_init_pkg::RV_WDT};
            reset_init_pkg::IX_CLK:
                reset_val = {25'h1000000, reset_init_pkg::RV_CLK};
            reset_init_pkg::IX_STBY:
                reset_val = {25'h1000000, reset_init_pkg::RV_STBY};
            default:
                reset_val = 33'h000000000;
        endcase
    endfunction : reset_val

    assign acc    = apb_req_i.psel && apb_req_i.penable && !pready_r;
    assign idx    = apb_req_i.paddr[7:2];
    // Writes land at the edge where pready is seen high
    assign commit = apb_req_i.psel && apb_req_i.penable && pready_r
                 && apb_req_i.pwrite;
    assign mapped = (idx < reset_init_pkg::IX_STATUS)
                 || (idx == reset_init_pkg::IX_STATUS);

    // Reset sequencer
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            seq_r      <= ST_IN_RESET;
            hold_cnt_r <= 4'h0;
        end else begin
            case (seq_r)
                ST_IN_RESET: begin
                    seq_r      <= ST_STRETCH;
                    hold_cnt_r <= 4'h1;
                end
                ST_STRETCH: begin
                    if (32'(hold_cnt_r) >= HOLD_CYC) begin
                        seq_r <= ST_RUN;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 4'h1;
                    end
                end
                ST_RUN:  seq_r <= ST_RUN;
                default: seq_r <= ST_IN_RESET;
            endcase
        end
    end

    // Internal reset stays high through the stretch
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            int_reset_r <= 1'b1;
        end else begin
            int_reset_r <= (seq_r != ST_RUN)
                && !(seq_r == ST_STRETCH
                     && 32'(hold_cnt_r) >= HOLD_CYC);
        end
    end

    // Count cycles with rst_i high, then fetch once with no hold
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            if (32'(low_cnt_r) < FETCH_CYC) begin
                low_cnt_r <= low_cnt_r + 6'h01;
            end
            fetch_r <= 1'b0;
            if (32'(low_cnt_r) + 1 >= FETCH_CYC && !fetch_done_r
                && !bus_hold_request_i) begin
                fetch_r      <= 1'b1;
                fetch_done_r <= 1'b1;
            end
        end else begin
            low_cnt_r    <= 6'h00;
            fetch_done_r <= 1'b0;
            fetch_r      <= 1'b0;
        end
    end

    // Register bank: defined registers load, others keep contents
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NR; i++) begin
            logic [32:0] rv;
            rv = reset_val(6'(i));
            if (rst_i) begin
                if (rv[32]) begin
                    regs_r[i] <= rv[31:0];
                end
            end else if (commit && idx == 6'(i)
                         && idx != reset_init_pkg::IX_GPR0
                         && idx != reset_init_pkg::IX_STATUS) begin
                regs_r[i] <= apb_req_i.pwdata;
            end
        end
    end

    // APB slave, one wait state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= acc;
            pslverr_r <= acc && !mapped;
            if (acc && !apb_req_i.pwrite) begin
                if (!mapped) begin
                    prdata_r <= 32'h00000000;
                end else if (idx == reset_init_pkg::IX_STATUS) begin
                    prdata_r <= {28'h0000000, fetch_done_r, int_reset_r,
                                 seq_r};
                end else if (idx == reset_init_pkg::IX_GPR0) begin
                    prdata_r <= 32'h00000000;
                end else begin
                    prdata_r <= regs_r[idx];
                end
            end else begin
                prdata_r <= 32'h00000000;
            end
        end
    end

    assign apb_rsp_o.pready  = pready_r;
    assign apb_rsp_o.pslverr = pslverr_r;
    assign apb_rsp_o.prdata  = prdata_r;
    assign int_reset_o       = int_reset_r;
    assign fetch_start_o     = fetch_r;

    a_stat_word_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |->
            regs_r[reset_init_pkg::IX_STAT_WORD] == 32'h00008000)
        else $error("status word reset value wrong");
    a_task_ctl_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |->
            regs_r[reset_init_pkg::IX_TASK_CTL] == 32'h000000e0)
        else $error("task control reset value wrong");
    a_exc_codes: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_FATAL] == 32'h0
            && regs_r[reset_init_pkg::IX_EXC] == 32'h0000fff0)
        else $error("exception code reset wrong");
    a_undef_keep: assert property (@(posedge mclk_i)
        rst_i && $past(rst_i) && !$past(rst_i, 2) |->
            regs_r[reset_init_pkg::IX_UNDEF0]
            == $past(regs_r[reset_init_pkg::IX_UNDEF0]))
        else $error("undefined register changed in reset");
    a_saved_keep: assert property (@(posedge mclk_i)
        rst_i && $past(rst_i) && !$past(rst_i, 2) |->
            regs_r[6'h2e] == $past(regs_r[6'h2e]))
        else $error("saved register changed in reset");
    a_port_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_PDIR] == 32'h000003ff)
        else $error("port direction reset wrong");
    a_pfsel_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_PFSEL] == 32'h00000000)
        else $error("port function select reset wrong");
    a_bus_type_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_BCTS] == 32'h00000001)
        else $error("bus type reset wrong");
    a_wait_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_WAITA] == 32'h00000077
            && regs_r[reset_init_pkg::IX_WAITB] == 32'h00000077
            && regs_r[reset_init_pkg::IX_WAITC] == 32'h00000077)
        else $error("wait state reset wrong");
    a_dram_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_DRAM] == 32'h00000081
            && regs_r[reset_init_pkg::IX_REFR] == 32'h00000080
            && regs_r[reset_init_pkg::IX_PROM] == 32'h00000080)
        else $error("memory config reset wrong");
    a_dma_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_DMAA] == 32'h00000000
            && regs_r[reset_init_pkg::IX_DMAB] == 32'h00000000)
        else $error("dma control reset wrong");
    a_timer_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_TUM] == 32'h00000a00
            && regs_r[reset_init_pkg::IX_TOC] == 32'h00000003)
        else $error("timer mode reset wrong");
    a_timer_zero: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_TMCA] == 32'h00000000
            && regs_r[reset_init_pkg::IX_TMCB] == 32'h00000000
            && regs_r[reset_init_pkg::IX_TOVF] == 32'h00000000
            && regs_r[reset_init_pkg::IX_TMA] == 32'h00000000
            && regs_r[reset_init_pkg::IX_TMB] == 32'h00000000)
        else $error("timer registers not cleared");
    a_serial_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_UMODE] == 32'h00000000
            && regs_r[reset_init_pkg::IX_USTAT] == 32'h00000000
            && regs_r[reset_init_pkg::IX_SMODE] == 32'h00000000
            && regs_r[reset_init_pkg::IX_BAUD_PRE] == 32'h00000000)
        else $error("serial registers not cleared");
    a_irq_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_IREQ] == 32'h00000000
            && regs_r[reset_init_pkg::IX_ICLR] == 32'h00000000
            && regs_r[reset_init_pkg::IX_IPRIO] == 32'h000000e4)
        else $error("irq registers reset wrong");
    a_wdt_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_WDT] == 32'h00000000)
        else $error("watchdog mode reset wrong");
    a_stby_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_STBY] == 32'h00000000)
        else $error("standby control reset wrong");
    a_ready_pulse: assert property (@(posedge mclk_i)
        pready_r |=> !pready_r)
        else $error("ready held longer than one cycle");
    a_err_unmapped: assert property (@(posedge mclk_i)
        acc && !mapped |=> pslverr_r && prdata_r == 32'h00000000)
        else $error("unmapped access not refused");
    a_rsp_reset: assert property (@(posedge mclk_i)
        rst_i |=> !pready_r && !pslverr_r)
        else $error("response active in reset");
    a_gpr0_read: assert property (@(posedge mclk_i)
        acc && !apb_req_i.pwrite && idx == reset_init_pkg::IX_GPR0
        |=> prdata_r == 32'h00000000)
        else $error("register zero read not zero");
    a_run_released: assert property (@(posedge mclk_i)
        seq_r == ST_RUN |-> !int_reset_o)
        else $error("internal reset high in run");
    a_fetch_once: assert property (@(posedge mclk_i)
        fetch_start_o |=> !fetch_start_o)
        else $error("fetch start longer than one cycle");
    a_imask_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_IMASK] == 32'h0000ffff)
        else $error("irq mask reset wrong");
    a_clk_reset: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_CLK] == 32'h00000003)
        else $error("clock control reset wrong");
    a_stretch_len: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> int_reset_o [*4])
        else $error("internal reset released early");
    a_pc_vector: assert property (@(posedge mclk_i)
        $fell(rst_i) |-> regs_r[reset_init_pkg::IX_PC] == 32'hfffffff0)
        else $error("pc reset vector wrong");
    a_fetch_hold: assert property (@(posedge mclk_i)
        fetch_start_o |-> !$past(bus_hold_request_i) && $past(rst_i))
        else $error("fetch started under hold");

    c_long_reset: cover property (@(posedge mclk_i) fetch_start_o);
    c_release: cover property (@(posedge mclk_i) $fell(int_reset_o));
    c_write: cover property (@(posedge mclk_i)
        acc && apb_req_i.pwrite ##1 pready_r);
    c_fetch_held: cover property (@(posedge mclk_i)
        bus_hold_request_i && rst_i ##1 !bus_hold_request_i ##1 fetch_r);
    c_unmapped: cover property (@(posedge mclk_i) acc && !mapped);

endmodule : reset_register_initializer

/* File: reset_register_initializer_tb_top.sv */
// Testbench for the reset register bank
`timescale 1ns/1ps
module reset_register_initializer_tb_top;
    localparam int HOLD_N  = 3;
    localparam int FETCH_N = 8;

    logic                     mclk        = 1'b0;
    logic                     rst         = 1'b1;
    logic                     bus_hold    = 1'b0;
    reset_init_pkg::apb_req_s apb_req     = '0;
    reset_init_pkg::apb_rsp_s apb_rsp;
    logic                     int_reset;
    logic                     fetch_start;
    int                       mismatches   = 0;
    int                       total_checks = 0;
    int                       fetch_n      = 0;
    int                       fetch_at     = 0;
    int                       rst_cnt      = 0;

    always #50 mclk = ~mclk;

    reset_register_initializer #(
        .HOLD_CYC  (HOLD_N),
        .FETCH_CYC (FETCH_N)
    ) reset_register_initializer_i (
        .mclk_i             (mclk),
        .rst_i              (rst),
        .bus_hold_request_i (bus_hold),
        .apb_req_i          (apb_req),
        .apb_rsp_o          (apb_rsp),
        .int_reset_o        (int_reset),
        .fetch_start_o      (fetch_start)
    );

    // Fetch pulses and the reset edge count they follow
    always @(posedge mclk) begin
        if (fetch_start === 1'b1) begin
            fetch_n  <= fetch_n + 1;
            fetch_at <= rst_cnt;
        end
        rst_cnt <= rst ? rst_cnt + 1 : 0;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1

    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= {idx, 2'b00};
        apb_req.pwdata  <= wd;
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        @(posedge mclk);
        while (apb_rsp.pready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 50) begin
            mismatches++;
            test_done();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, idx, wd, d, e);
    endtask : wr

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, idx, 32'h0, d, e);
        chk32(d, exp);
        chk1(e, 1'b0);
    endtask : rd_chk

    task automatic span_chk(input int lo, input int hi,
                            input logic [31:0] exp);
        for (int i = lo; i <= hi; i++) begin
            rd_chk(6'(i), exp);
        end
    endtask : span_chk

    task automatic do_reset(input int n, input int h);
        @(posedge mclk);
        rst      <= 1'b1;
        bus_hold <= (h > 0);
        for (int i = 1; i <= n; i++) begin
            @(posedge mclk);
            bus_hold <= (i < h);
            if (i == n) begin
                rst <= 1'b0;
            end
        end
    endtask : do_reset

    task automatic t_int_hold();
        do_reset(5, 0);
        for (int i = 1; i <= HOLD_N + 1; i++) begin
            @(posedge mclk);
            #1;
            chk1(int_reset, i <= HOLD_N);
        end
    endtask : t_int_hold

    task automatic t_reset_values();
        rd_chk(reset_init_pkg::IX_PC, reset_init_pkg::RV_PC);
        rd_chk(reset_init_pkg::IX_GPR0, reset_init_pkg::RV_GPR0);
        rd_chk(reset_init_pkg::IX_STAT_WORD, 32'h00008000);
        rd_chk(reset_init_pkg::IX_TASK_CTL, 32'h000000e0);
        rd_chk(reset_init_pkg::IX_FATAL, 32'h0000);
        rd_chk(reset_init_pkg::IX_EXC, 32'hfff0);
        rd_chk(reset_init_pkg::IX_PDIR, 32'h03ff);
        rd_chk(reset_init_pkg::IX_PFSEL, 32'h0000);
        rd_chk(reset_init_pkg::IX_BCTS, 32'h01);
        span_chk(32'h09, 32'h0b, 32'h77);
        rd_chk(reset_init_pkg::IX_DRAM, 32'h81);
        span_chk(32'h0d, 32'h0e, 32'h80);
        span_chk(32'h0f, 32'h10, 32'h0000);
        rd_chk(reset_init_pkg::IX_TUM, 32'h0a00);
        rd_chk(reset_init_pkg::IX_TOC, 32'h03);
        span_chk(32'h13, 32'h17, 32'h00);
        span_chk(32'h18, 32'h1b, 32'h00);
        rd_chk(reset_init_pkg::IX_IMASK, 32'hffff);
        span_chk(32'h1d, 32'h1e, 32'h0000);
        rd_chk(reset_init_pkg::IX_IPRIO, 32'he4);
        rd_chk(reset_init_pkg::IX_WDT, 32'h00);
        rd_chk(reset_init_pkg::IX_CLK, 32'h03);
        rd_chk(reset_init_pkg::IX_STBY, 32'h00);
    endtask : t_reset_values

    task automatic t_refused();
        logic [31:0] d;
        logic        e;
        wr(reset_init_pkg::IX_GPR0, 32'hffffffff);
        rd_chk(reset_init_pkg::IX_GPR0, 32'h0);
        apb(1'b0, 6'h30, 32'h0, d, e);
        chk1(e, 1'b1);
        chk32(d, 32'h0);
    endtask : t_refused

    task automatic t_retain();
        wr(reset_init_pkg::IX_UNDEF0, 32'h5a5ac3c3);
        wr(6'h2e, 32'ha5a53c3c);
        wr(reset_init_pkg::IX_STAT_WORD, 32'h00000001);
        wr(reset_init_pkg::IX_IMASK, 32'h0);
        do_reset(5, 0);
        rd_chk(reset_init_pkg::IX_UNDEF0, 32'h5a5ac3c3);
        rd_chk(6'h2e, 32'ha5a53c3c);
        rd_chk(reset_init_pkg::IX_STAT_WORD, 32'h00008000);
        rd_chk(reset_init_pkg::IX_IMASK, 32'hffff);
        wr(reset_init_pkg::IX_CLK, 32'h00000001);
        rd_chk(reset_init_pkg::IX_CLK, 32'h00000001);
    endtask : t_retain

    task automatic t_fetch();
        int n0;
        n0 = fetch_n;
        do_reset(FETCH_N + 2, 0);
        repeat (2) @(posedge mclk);
        chk32(32'(fetch_n - n0), 32'd1);
        chk32(32'(fetch_at), 32'(FETCH_N));
        n0 = fetch_n;
        do_reset(FETCH_N + 6, FETCH_N + 2);
        repeat (2) @(posedge mclk);
        chk32(32'(fetch_n - n0), 32'd1);
        chk32(32'(fetch_at), 32'(FETCH_N + 3));
    endtask : t_fetch

    initial begin
        do_reset(5, 0);
        chk32(32'(fetch_n), 32'd0);
        wr(reset_init_pkg::IX_UNDEF0, 32'h00000000);
        wr(6'h2e, 32'h00000000);
        t_int_hold();
        t_reset_values();
        t_refused();
        t_retain();
        t_fetch();
        test_done();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        test_done();
    end
endmodule : reset_register_initializer_tb_top
